/* File: src/sbc_defines.svh */
// Bit positions, reset values and counts shared by the diagnosis and interrupt-enable logic.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_SEL_HI_BIT          15
`define SBC_SEL_LO_BIT          14
`define SBC_READBACK_SEL_BIT    13
`define SBC_SUPPRESS_WR_BIT     12
`define SBC_WD_TIMEOUT_EN_BIT   11
`define SBC_OVERHEAT_EN_BIT     10
`define SBC_CLK_FAULT_EN_BIT    8
`define SBC_MODE_DATA_HI        11
`define SBC_LOW_EN_HI           7

`define SBC_FRAME_BITS          5'h10
`define SBC_COUNT_MAX           5'h1F
`define SBC_FIRST_DATA_COUNT    5'h03
`define SBC_TOP_BIT             5'h0F

`define SBC_FAULT_TX_STUCK      2'h3
`define SBC_FAULT_SHORT_GND     2'h2
`define SBC_FAULT_SHORT_BAT     2'h1
`define SBC_FAULT_NONE          2'h0
`define SBC_DIAG_RSVD_BIT3      1'h1
`define SBC_MAIN_OK_RST         1'h1
`define SBC_EN_RST              1'h0
`define SBC_LOW_EN_RST          8'h00
`define SBC_WORD_RST            16'h0000

`endif

/* File: src/sbc_pkg.sv */
// Types shared by the diagnosis and interrupt-enable register block.
package sbc_pkg;

    typedef logic [15:0] sbc_word_t;

    typedef enum logic [1:0] {
        SBC_SEL_DIAG  = 2'b00,
        SBC_SEL_IE    = 2'b01,
        SBC_SEL_SPARE = 2'b10,
        SBC_SEL_OTHER = 2'b11
    } sbc_sel_t;

endpackage : sbc_pkg

/* File: src/sbc_link_if.sv */
// Signals between the serial link logic and the system-clock register core.
`timescale 1ns/1ps
`default_nettype none

interface sbc_link_if;
    sbc_pkg::sbc_word_t rxWord;
    logic [4:0]         bitCount;
    logic               frameTog;
    sbc_pkg::sbc_word_t diagSnap;
    sbc_pkg::sbc_word_t ieSnap;
    sbc_pkg::sbc_word_t causeSnap;

    modport link (output rxWord, output bitCount, output frameTog,
                  input diagSnap, input ieSnap, input causeSnap);
    modport core (input rxWord, input bitCount, input frameTog,
                  output diagSnap, output ieSnap, output causeSnap);
endinterface : sbc_link_if

`default_nettype wire

/* File: src/sbc_sync2.sv */
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
`default_nettype none

module sbc_sync2 (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic stage1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            q      <= 1'b0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : sbc_sync2

`default_nettype wire

/* File: src/sbc_spi_link.sv */
// Serial link end on the serial clock: shifts frames in, counts clocks, shifts readback out.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module sbc_spi_link (
    input  wire logic   spiClk,
    input  wire logic   rst,
    input  wire logic   spiCsN,
    input  wire logic   spiMosi,
    output logic        spiMiso,
    output logic        spiMisoOe,
    sbc_link_if.link    lk
);
    logic               fresh;
    logic               freshRst;
    sbc_pkg::sbc_word_t selWord;
    sbc_pkg::sbc_word_t outWord;
    logic [3:0]         bitIdx;

    // The serial clock stops between frames, so frame start is marked by chip select.
    assign freshRst = rst | spiCsN;
    assign spiMisoOe = ~spiCsN;

    always_ff @(posedge spiClk or posedge freshRst) begin
        if (freshRst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // The counter saturates so an overlong frame never wraps back to a legal count.
    always_ff @(posedge spiClk or posedge rst) begin
        if (rst) begin
            lk.rxWord   <= `SBC_WORD_RST;
            lk.bitCount <= 5'h00;
            lk.frameTog <= 1'b0;
        end else begin
            lk.rxWord <= {lk.rxWord[14:0], spiMosi};
            if (fresh) begin
                lk.bitCount <= 5'h01;
                lk.frameTog <= ~lk.frameTog;
            end else if (lk.bitCount != `SBC_COUNT_MAX) begin
                lk.bitCount <= lk.bitCount + 5'h01;
            end
        end
    end

    // Readback source is known once the three selector bits are in.
    always_comb begin
        outWord = `SBC_WORD_RST;
        case (sbc_pkg::sbc_sel_t'(lk.rxWord[2:1]))
            sbc_pkg::SBC_SEL_DIAG: outWord = lk.diagSnap;
            sbc_pkg::SBC_SEL_IE:   outWord = lk.rxWord[0] ? lk.causeSnap : lk.ieSnap;
            default:               outWord = `SBC_WORD_RST;
        endcase
    end

    assign bitIdx = 4'(`SBC_TOP_BIT - lk.bitCount);

    always_ff @(negedge spiClk or posedge rst) begin
        if (rst) begin
            selWord <= `SBC_WORD_RST;
            spiMiso <= 1'b0;
        end else begin
            if (lk.bitCount == `SBC_FIRST_DATA_COUNT) begin
                selWord <= outWord;
                spiMiso <= outWord[bitIdx];
            end else if (lk.bitCount > `SBC_FIRST_DATA_COUNT &&
                         lk.bitCount < `SBC_FRAME_BITS) begin
                spiMiso <= selWord[bitIdx];
            end else begin
                spiMiso <= 1'b0;
            end
        end
    end
endmodule : sbc_spi_link

`default_nettype wire

/* File: src/sbc_diag_irq_regs.sv */
// Diagnosis and interrupt-enable registers of the system basis chip, reached by serial frames.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module sbc_diag_irq_regs (
    input  wire logic   clock,
    input  wire logic   rst,
    input  wire logic   spiClk,
    input  wire logic   spiCsN,
    input  wire logic   spiMosi,
    output logic        spiMiso,
    output logic        spiMisoOe,
    input  wire logic   txStuckDominant,
    input  wire logic   lineShortGround,
    input  wire logic   lineShortBattery,
    input  wire logic   secondaryRegulatorOk,
    input  wire logic   mainSupplyUndervoltage,
    input  wire logic   overTemperatureWarn,
    input  wire logic   watchdogOverflow,
    input  wire logic   standbyMode,
    input  wire logic   startupOrRestartMode,
    output logic        modeWrite,
    output logic [11:0] modeData,
    output logic [7:0]  lowIrqEnables,
    output logic        irqPending,
    output logic        resetRequest
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    sbc_link_if         lk ();
    logic               csHigh;
    logic               csLowSync;
    logic               csPrev;
    logic               togSync;
    logic               togSeen;
    logic               frameEnd;
    logic               countOk;
    logic               goodFrame;
    logic               badFrame;
    sbc_pkg::sbc_sel_t  frameSel;
    logic               suppressWrite;
    logic               readbackSourceSelect;
    logic               diagRead;
    logic               causeRead;
    logic               ieWrite;
    logic [1:0]         busLineFaultCode;
    logic               mainSupplyOkLatch;
    logic               uvAfterSnap;
    logic               watchdogTimeoutIrqEn;
    logic               overheatIrqEn;
    logic               clockCountFaultIrqEn;
    logic               tempPrev;
    logic               wdIrq;
    logic               wdReset;
    logic               tempIrq;
    logic               spiFaultIrq;
    logic               spiFaultReset;
    logic [2:0]         causeBits;
    sbc_pkg::sbc_word_t diagWord;
    sbc_pkg::sbc_word_t ieWord;
    sbc_pkg::sbc_word_t causeWord;

    function automatic logic sel_is(input sbc_pkg::sbc_sel_t sel, input sbc_pkg::sbc_sel_t code);
        return sel == code;
    endfunction : sel_is

    ////////////////////////////////////////////////////////////////////////////
    // Serial link and crossing of frame boundaries.
    sbc_spi_link u_link (
        .spiClk    (spiClk),
        .rst       (rst),
        .spiCsN    (spiCsN),
        .spiMosi   (spiMosi),
        .spiMiso   (spiMiso),
        .spiMisoOe (spiMisoOe),
        .lk        (lk.link)
    );

    // Chip select crosses inverted so the flops' reset level matches an idle line.
    // Otherwise the release of reset would look like the end of a frame.
    sbc_sync2 u_cs_sync (
        .clock (clock),
        .rst   (rst),
        .d     (~spiCsN),
        .q     (csLowSync)
    );

    assign csHigh = ~csLowSync;

    // The link toggles once per frame that saw any clock; an unchanged toggle means zero clocks.
    sbc_sync2 u_tog_sync (
        .clock (clock),
        .rst   (rst),
        .d     (lk.frameTog),
        .q     (togSync)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csHigh;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            togSeen <= 1'b0;
        end else if (frameEnd) begin
            togSeen <= togSync;
        end
    end

    // Received word and count are still once chip select is high, so reading them here is safe.
    assign frameEnd             = csHigh & ~csPrev;
    assign countOk              = (togSync != togSeen) && (lk.bitCount == `SBC_FRAME_BITS);
    assign goodFrame            = frameEnd & countOk;
    assign badFrame             = frameEnd & ~countOk;
    assign frameSel             = sbc_pkg::sbc_sel_t'(lk.rxWord[`SBC_SEL_HI_BIT:`SBC_SEL_LO_BIT]);
    assign suppressWrite        = lk.rxWord[`SBC_SUPPRESS_WR_BIT];
    assign readbackSourceSelect = lk.rxWord[`SBC_READBACK_SEL_BIT];
    assign diagRead   = goodFrame & sel_is(frameSel, sbc_pkg::SBC_SEL_DIAG);
    assign ieWrite    = goodFrame & sel_is(frameSel, sbc_pkg::SBC_SEL_IE) & ~suppressWrite;
    assign causeRead  = goodFrame & sel_is(frameSel, sbc_pkg::SBC_SEL_IE)
                        & readbackSourceSelect;

    ////////////////////////////////////////////////////////////////////////////
    // Readback snapshots, frozen while chip select is low so the link sees still words.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lk.diagSnap  <= `SBC_WORD_RST;
            lk.ieSnap    <= `SBC_WORD_RST;
            lk.causeSnap <= `SBC_WORD_RST;
        end else if (csHigh) begin
            lk.diagSnap  <= diagWord;
            lk.ieSnap    <= ieWord;
            lk.causeSnap <= causeWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diagnosis word.
    always_comb begin
        if (txStuckDominant) begin
            busLineFaultCode = `SBC_FAULT_TX_STUCK;
        end else if (lineShortGround) begin
            busLineFaultCode = `SBC_FAULT_SHORT_GND;
        end else if (lineShortBattery) begin
            busLineFaultCode = `SBC_FAULT_SHORT_BAT;
        end else begin
            busLineFaultCode = `SBC_FAULT_NONE;
        end
    end

    assign diagWord = {4'h0, 5'h00, busLineFaultCode, secondaryRegulatorOk,
                       `SBC_DIAG_RSVD_BIT3, mainSupplyOkLatch, 2'h0};

    // A dip seen after the snapshot was frozen was not reported, so the read must not clear it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            uvAfterSnap <= 1'b0;
        end else begin
            uvAfterSnap <= mainSupplyUndervoltage | (uvAfterSnap & ~csPrev);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mainSupplyOkLatch <= `SBC_MAIN_OK_RST;
        end else if (mainSupplyUndervoltage) begin
            mainSupplyOkLatch <= 1'b0;
        end else if (diagRead) begin
            mainSupplyOkLatch <= ~uvAfterSnap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register write port; the mode register itself lives elsewhere.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeWrite <= 1'b0;
            modeData  <= 12'h000;
        end else begin
            modeWrite <= diagRead & ~suppressWrite;
            if (diagRead & ~suppressWrite) begin
                modeData <= lk.rxWord[`SBC_MODE_DATA_HI:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enables.
    // The watchdog overflow clear beats a simultaneous software set: fail-safe wins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            watchdogTimeoutIrqEn <= `SBC_EN_RST;
            overheatIrqEn        <= `SBC_EN_RST;
            clockCountFaultIrqEn <= `SBC_EN_RST;
            lowIrqEnables        <= `SBC_LOW_EN_RST;
        end else begin
            if (ieWrite) begin
                watchdogTimeoutIrqEn <= lk.rxWord[`SBC_WD_TIMEOUT_EN_BIT];
                overheatIrqEn        <= lk.rxWord[`SBC_OVERHEAT_EN_BIT];
                clockCountFaultIrqEn <= lk.rxWord[`SBC_CLK_FAULT_EN_BIT];
                lowIrqEnables        <= lk.rxWord[`SBC_LOW_EN_HI:0];
            end
            if (watchdogOverflow) begin
                watchdogTimeoutIrqEn <= 1'b0;
            end
        end
    end

    assign ieWord = {4'h0, watchdogTimeoutIrqEn, overheatIrqEn, 1'b0,
                     clockCountFaultIrqEn, lowIrqEnables};

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events and reset requests.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tempPrev <= 1'b0;
        end else begin
            tempPrev <= overTemperatureWarn;
        end
    end

    assign wdIrq         = watchdogOverflow & watchdogTimeoutIrqEn & standbyMode;
    assign wdReset       = watchdogOverflow & ~(watchdogTimeoutIrqEn & standbyMode);
    assign tempIrq       = (overTemperatureWarn ^ tempPrev) & overheatIrqEn;
    assign spiFaultIrq   = badFrame & clockCountFaultIrqEn & ~startupOrRestartMode;
    assign spiFaultReset = badFrame & clockCountFaultIrqEn & startupOrRestartMode;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resetRequest <= 1'b0;
        end else begin
            resetRequest <= wdReset | spiFaultReset;
        end
    end

    // Only bits the read actually returned are cleared; a new event always sets.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            causeBits <= 3'h0;
        end else begin
            causeBits <= (causeBits & ~(causeRead ? {lk.causeSnap[`SBC_WD_TIMEOUT_EN_BIT],
                                                     lk.causeSnap[`SBC_OVERHEAT_EN_BIT],
                                                     lk.causeSnap[`SBC_CLK_FAULT_EN_BIT]}
                                                  : 3'h0))
                         | {wdIrq, tempIrq, spiFaultIrq};
        end
    end

    assign causeWord  = {4'h0, causeBits[2], causeBits[1], 1'b0, causeBits[0], 8'h00};
    assign irqPending = |causeBits;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_diag_reserved_bits: assert property (
        diagWord[11:7] == 5'h00 && diagWord[3] && diagWord[1:0] == 2'h0)
        else $error("diagnosis reserved bits wrong");
    a_line_fault_stuck: assert property (
        txStuckDominant |-> diagWord[6:5] == 2'h3)
        else $error("stuck transmit not coded 11");
    a_line_fault_gnd: assert property (
        !txStuckDominant && lineShortGround |-> diagWord[6:5] == 2'h2)
        else $error("ground short not coded 10");
    a_sec_reg_bit: assert property (
        diagWord[4] == secondaryRegulatorOk)
        else $error("secondary regulator bit wrong");
    a_uv_latch_low: assert property (
        mainSupplyUndervoltage |=> !mainSupplyOkLatch ##1 (!mainSupplyOkLatch || diagRead))
        else $error("undervoltage latch not held low");
    a_mode_write_pulse: assert property (
        diagRead && !suppressWrite |=> modeWrite && modeData == $past(lk.rxWord[11:0]))
        else $error("mode write missing or wrong");
    a_mode_read_only: assert property (
        modeWrite |-> $past(diagRead) && !$past(suppressWrite))
        else $error("mode written without a writing frame");
    a_ie_write_data: assert property (
        ieWrite && !watchdogOverflow |=> ieWord[11:0] == ($past(lk.rxWord[11:0]) & 12'hDFF))
        else $error("enable write not applied");
    a_ie_hold_stable: assert property (
        !ieWrite && !watchdogOverflow |=> $stable(ieWord))
        else $error("enables changed without a write");
    a_bit9_zero: assert property (ieWord[9] == 1'b0)
        else $error("reserved enable bit reads one");
    a_wd_autoclear: assert property (
        watchdogOverflow |=> !watchdogTimeoutIrqEn)
        else $error("watchdog enable not cleared");
    a_wd_reset_req: assert property (
        watchdogOverflow && !(watchdogTimeoutIrqEn && standbyMode) |=> resetRequest)
        else $error("watchdog overflow did not request reset");
    a_temp_cross_irq: assert property (
        overheatIrqEn && $changed(overTemperatureWarn) |=> causeBits[1])
        else $error("temperature crossing lost");
    a_clk_fault_irq: assert property (
        badFrame && clockCountFaultIrqEn && !startupOrRestartMode |=> causeBits[0] && irqPending)
        else $error("clock count fault not flagged");
    a_bad_frame_quiet: assert property (
        badFrame && !clockCountFaultIrqEn |=> !modeWrite && !resetRequest[*1])
        else $error("discarded frame had an effect");

    c_diag_read: cover property (diagRead ##1 modeWrite);
    c_ie_write: cover property (ieWrite);
    c_cause_read: cover property (causeRead && irqPending);
    c_wd_irq: cover property (wdIrq);
endmodule : sbc_diag_irq_regs

`default_nettype wire

/* File: tb/sbc_spi_master.sv */
// Serial master model that sends one frame and captures the readback word.
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_master (
    output logic      spiClk,
    output logic      spiCsN,
    output logic      spiMosi,
    input  wire logic spiMiso
);
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // The clock stands low between frames, and data flips after release so a stale bit is
    // never mistaken for a driven one. A count other than 16 is sent only when asked.
    task automatic xfer(input logic [15:0] word, input int edges, output logic [15:0] rd);
        rd = 16'h0000;
        spiCsN = 1'b0;
        #320;
        for (int i = 0; i < edges; i++) begin
            spiMosi = word[15 - (i % 16)];
            #40 spiClk = 1'b1;
            rd = {rd[14:0], spiMiso};
            #40 spiClk = 1'b0;
        end
        #120 spiCsN = 1'b1;
        spiMosi = ~spiMosi;
        #600;
    endtask : xfer
endmodule : sbc_spi_master

`default_nettype wire

/* File: tb/test_sbc_diag_irq_regs.sv */
// Self-checking bench for the diagnosis and interrupt-enable block.
`timescale 1ns/1ps
`default_nettype none

module test_sbc_diag_irq_regs;
    logic        clock = 1'b0, rst = 1'b1, spiClk, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic        txStuckDominant = 1'b0, lineShortGround = 1'b0, lineShortBattery = 1'b0;
    logic        secondaryRegulatorOk = 1'b1, mainSupplyUndervoltage = 1'b0;
    logic        overTemperatureWarn = 1'b0, watchdogOverflow = 1'b0;
    logic        standbyMode = 1'b0, startupOrRestartMode = 1'b0;
    logic        modeWrite, irqPending, resetRequest;
    logic [11:0] modeData;
    logic [7:0]  lowIrqEnables;
    logic [15:0] rd;
    int          mismatches = 0, cmp_count = 0, mwCount = 0, rrCount = 0, oeBad = 0;

    sbc_diag_irq_regs dut (.clock, .rst, .spiClk, .spiCsN, .spiMosi, .spiMiso, .spiMisoOe,
        .txStuckDominant, .lineShortGround, .lineShortBattery, .secondaryRegulatorOk,
        .mainSupplyUndervoltage, .overTemperatureWarn, .watchdogOverflow, .standbyMode,
        .startupOrRestartMode, .modeWrite, .modeData, .lowIrqEnables, .irqPending,
        .resetRequest);
    sbc_spi_master host (.spiClk, .spiCsN, .spiMosi, .spiMiso);

    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (modeWrite === 1'b1) mwCount++;
        if (resetRequest === 1'b1) rrCount++;
    end
    // The output enable must stand high at every serial clock rise inside a frame.
    always @(posedge spiClk) begin
        if (spiMisoOe !== 1'b1) oeBad++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (exp !== got) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Bits 15..13 of the readback carry no data, so only 12..0 are compared.
    task automatic frame(input logic [15:0] w, input int n);
        host.xfer(w, n, rd);
        rd = rd & 16'h1FFF;
        chk("miso enable idle", 16'h0000, {15'h0000, spiMisoOe});
    endtask : frame

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    task automatic t_diag;
        for (int i = 3; i >= 0; i--) begin
            @(posedge clock);
            txStuckDominant <= (i == 3);
            lineShortGround <= (i == 2);
            lineShortBattery <= (i == 1);
            secondaryRegulatorOk <= ~i[0];
            repeat (3) @(posedge clock);
            frame(16'h3000, 16);
            chk("diag", {9'h000, i[1:0], ~i[0], 4'b1100}, rd);
        end
        chk("mode writes", 16'h0000, 16'(mwCount));
        $display("t_diag done");
    endtask : t_diag

    task automatic t_uv;
        @(posedge clock) mainSupplyUndervoltage <= 1'b1;
        @(posedge clock) mainSupplyUndervoltage <= 1'b0;
        repeat (3) @(posedge clock);
        frame(16'h3000, 16);
        chk("diag dip", 16'h0018, rd);
        frame(16'h3000, 16);
        chk("diag reread", 16'h001C, rd);
        frame(16'h2A5C, 16);
        chk("mode writes", 16'h0001, 16'(mwCount));
        chk("mode data", 16'h0A5C, {4'h0, modeData});
        frame(16'h8123, 16);
        chk("spare select readback", 16'h0000, rd);
        chk("spare select writes", 16'h0001, 16'(mwCount));
        chk("spare select data", 16'h0A5C, {4'h0, modeData});
        $display("t_uv done");
    endtask : t_uv

    task automatic t_ie;
        frame(16'h5000, 16);
        chk("enables at reset", 16'h0000, rd);
        frame(16'h4DFF, 16);
        for (int i = 0; i < 2; i++) begin
            frame(16'h5000, 16);
            chk("enables", 16'h0DFF, rd);
        end
        chk("low enables", 16'h00FF, {8'h00, lowIrqEnables});
        $display("t_ie done");
    endtask : t_ie

    task automatic t_evt;
        @(posedge clock);
        standbyMode <= 1'b1;
        watchdogOverflow <= 1'b1;
        @(posedge clock);
        watchdogOverflow <= 1'b0;
        overTemperatureWarn <= 1'b1;
        repeat (3) @(posedge clock);
        chk("irq pending", 16'h0001, {15'h0000, irqPending});
        frame(16'h5000, 16);
        chk("enables after overflow", 16'h05FF, rd);
        frame(16'h7000, 16);
        chk("cause", 16'h0C00, rd);
        frame(16'h7000, 16);
        chk("cause cleared", 16'h0000, rd);
        @(posedge clock) watchdogOverflow <= 1'b1;
        @(posedge clock) watchdogOverflow <= 1'b0;
        repeat (3) @(posedge clock);
        chk("reset requests", 16'h0001, 16'(rrCount));
        $display("t_evt done");
    endtask : t_evt

    task automatic t_bad;
        frame(16'h4000, 15);
        frame(16'h7000, 16);
        chk("count fault cause", 16'h0100, rd);
        @(posedge clock) startupOrRestartMode <= 1'b1;
        frame(16'h4000, 15);
        chk("reset requests", 16'h0002, 16'(rrCount));
        @(posedge clock) startupOrRestartMode <= 1'b0;
        frame(16'h4000, 16);
        frame(16'h4FFF, 15);
        frame(16'h5000, 16);
        chk("dropped write", 16'h0000, rd);
        frame(16'h7000, 16);
        chk("no count cause", 16'h0000, rd);
        chk("dropped frame resets", 16'h0002, 16'(rrCount));
        chk("miso enable low", 16'h0000, 16'(oeBad));
        $display("t_bad done");
    endtask : t_bad
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        t_diag();
        t_uv();
        t_ie();
        t_evt();
        t_bad();
        close_out();
    end
endmodule : test_sbc_diag_irq_regs

`default_nettype wire
